/* File: fpud_pkg.sv */
/*
 * Shared constants and carrier types for the underflow post-processing stage.
 * Assumes a single clock and synchronous active-low reset in every user.
 */
`default_nettype none

package fpud_pkg;

    // Destination formats.
    typedef enum logic [1:0] {
        FPUD_DST_SINGLE = 2'b00,
        FPUD_DST_DOUBLE = 2'b01,
        FPUD_DST_EXTEND = 2'b11
    } fpud_fmt_t;

    localparam int unsigned FPUD_EXP_W   = 18;
    localparam int unsigned FPUD_SIG_W   = 64;
    localparam int unsigned FPUD_SHIFT_W = 7;

    // Minimum unbiased exponents per destination.
    localparam logic signed [FPUD_EXP_W-1:0] FPUD_EMIN_SINGLE = -18'sd126;
    localparam logic signed [FPUD_EXP_W-1:0] FPUD_EMIN_DOUBLE = -18'sd1023;
    localparam logic signed [FPUD_EXP_W-1:0] FPUD_EMIN_EXTEND = -18'sd16383;

    // Rebias constant for unmasked register-destination underflow.
    localparam logic signed [FPUD_EXP_W-1:0] FPUD_REBIAS = 18'sd24576;

    // Single-precision denormal store: 24-bit significand, bias 126.
    localparam int unsigned                  FPUD_SGL_SIG_W = 24;
    localparam logic signed [FPUD_EXP_W-1:0] FPUD_SGL_BIAS  = 18'sd126;

    // Register tag codes.
    localparam logic [1:0] FPUD_TAG_VALID   = 2'b00;
    localparam logic [1:0] FPUD_TAG_ZERO    = 2'b01;
    localparam logic [1:0] FPUD_TAG_SPECIAL = 2'b10;

    typedef struct packed {
        logic                          sign;
        logic signed [FPUD_EXP_W-1:0]  exp;
        logic [FPUD_SIG_W-1:0]         sig;
        fpud_fmt_t                     fmt;
        logic                          to_reg;
    } fpud_opnd_t;

    typedef struct packed {
        logic                          sign;
        logic signed [FPUD_EXP_W-1:0]  exp;
        logic [FPUD_SIG_W-1:0]         sig;
        logic [1:0]                    tag;
        logic                          to_reg;
        logic                          denorm;
    } fpud_res_t;

endpackage : fpud_pkg

`default_nettype wire

/* File: fpud_shift.sv */
/*
 * One denormalisation step: exponent up by one, significand right by one.
 * Assumes the caller decides when to step; purely combinational.
 */
`default_nettype none

module fpud_shift
    import fpud_pkg::*;
(
    input  wire logic signed [FPUD_EXP_W-1:0] exp_i,  // Exponent in.
    input  wire logic [FPUD_SIG_W-1:0]        sig_i,  // Significand in.
    output logic signed [FPUD_EXP_W-1:0]      exp_o,  // Exponent plus one.
    output logic [FPUD_SIG_W-1:0]             sig_o   // Shifted significand.
);

    always_comb begin
        exp_o = exp_i + 18'sd1;
        sig_o = {1'b0, sig_i[FPUD_SIG_W-1:1]};
    end

endmodule : fpud_shift

`default_nettype wire

/* File: fpud_core.sv */
/*
 * Underflow detection and handling stage behind the arithmetic units.
 * Assumes the upstream units deliver normalised exact results.
 */
`default_nettype none

module fpud_core
    import fpud_pkg::*;
(
    input  wire logic       clk_i,        // 200 MHz clock.
    input  wire logic       reset_n_i,    // Synchronous reset, active low.
    input  wire logic       in_valid_i,   // Operand presented.
    output logic            in_ready_o,   // Stage idle and accepts.
    input  wire fpud_opnd_t in_i,         // Exact result from arithmetic.
    input  wire logic       uf_mask_i,    // Underflow mask from control word.
    input  wire logic       uf_clear_i,   // Software clears the sticky flag.
    input  wire logic       resume_i,     // Handler done, leave halt.
    output logic            out_valid_o,  // Result pulse for reg or store.
    output fpud_res_t       out_o,        // Result, exp field zero if denormal.
    output logic            irq_o,        // Interrupt request, level.
    output logic            halted_o,     // Execution halted.
    output logic            uf_sticky_o   // Sticky underflow status.
);

    ////////////////////////////////////////////////////////////////////////

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DNRM = 2'b01,
        ST_DONE = 2'b11,
        ST_HALT = 2'b10
    } fpud_state_t;

    typedef struct packed {
        fpud_state_t                  st;
        fpud_opnd_t                   op;
        logic signed [FPUD_EXP_W-1:0] emin;
        logic                         mask;
        logic                         oval;
        fpud_res_t                    res;
        logic                         irq;
        logic                         sticky;
        logic                         uf;
    } fpud_regs_t;

    fpud_regs_t q, d;

    logic signed [FPUD_EXP_W-1:0] step_exp;
    logic [FPUD_SIG_W-1:0]        step_sig;
    logic signed [FPUD_EXP_W-1:0] in_emin;
    logic                         in_uf;
    logic [FPUD_SIG_W-1:0]        rnd_sig;

    fpud_shift u_shift (
        .exp_i (q.op.exp),
        .sig_i (q.op.sig),
        .exp_o (step_exp),
        .sig_o (step_sig)
    );

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        case (in_i.fmt)
            FPUD_DST_SINGLE: in_emin = FPUD_EMIN_SINGLE;
            FPUD_DST_DOUBLE: in_emin = FPUD_EMIN_DOUBLE;
            default:         in_emin = FPUD_EMIN_EXTEND;
        endcase
        in_uf = in_i.exp < in_emin;
    end

    // Round to nearest at 24 bits. A carry into the integer bit turns the largest
    // denormal into the smallest normal, which then leaves as a normal result.
    always_comb begin
        rnd_sig = q.op.sig;
        if (q.op.fmt == FPUD_DST_SINGLE) begin
            rnd_sig = {q.op.sig[FPUD_SIG_W-1:FPUD_SIG_W-FPUD_SGL_SIG_W], 40'h0}
                    + {23'h0, q.op.sig[FPUD_SIG_W-FPUD_SGL_SIG_W-1], 40'h0};
        end
    end

    always_comb begin
        d      = q;
        d.oval = 1'b0;
        if (uf_clear_i) begin
            d.sticky = 1'b0;
        end
        case (q.st)
            ST_IDLE: begin
                if (in_valid_i) begin
                    d.op   = in_i;
                    d.emin = in_emin;
                    d.mask = uf_mask_i;
                    d.uf   = in_uf;
                    if (!in_uf) begin
                        d.st = ST_DONE;
                    end else begin
                        d.sticky = 1'b1;
                        if (uf_mask_i) begin
                            d.st = ST_DNRM;
                        end else if (in_i.to_reg) begin
                            d.op.exp = in_i.exp + FPUD_REBIAS;
                            d.st     = ST_DONE;
                        end else begin
                            d.irq = 1'b1;
                            d.st  = ST_HALT;
                        end
                    end
                end
            end
            ST_DNRM: begin
                if (q.op.exp < q.emin) begin
                    d.op.exp = step_exp;
                    d.op.sig = step_sig;
                end else begin
                    d.st = ST_DONE;
                end
            end
            ST_DONE: begin
                d.oval       = 1'b1;
                d.res.sign   = q.op.sign;
                d.res.to_reg = q.op.to_reg;
                d.res.sig    = q.op.sig;
                d.res.exp    = q.op.exp;
                d.res.tag    = FPUD_TAG_VALID;
                d.res.denorm = 1'b0;
                d.st         = ST_IDLE;
                if (q.op.sig == 64'h0) begin
                    d.res.exp = '0;
                    d.res.tag = FPUD_TAG_ZERO;
                end else if (!q.op.sig[FPUD_SIG_W-1]) begin
                    d.res.exp    = '0;
                    d.res.tag    = FPUD_TAG_SPECIAL;
                    d.res.denorm = 1'b1;
                    if (q.op.fmt == FPUD_DST_SINGLE) begin
                        d.res.sig = {1'b0, rnd_sig[FPUD_SIG_W-2:0]};
                        if (rnd_sig[FPUD_SIG_W-1]) begin
                            d.res.exp    = q.op.exp;
                            d.res.sig    = rnd_sig;
                            d.res.tag    = FPUD_TAG_VALID;
                            d.res.denorm = 1'b0;
                        end else if (rnd_sig == 64'h0) begin
                            d.res.tag    = FPUD_TAG_ZERO;
                            d.res.denorm = 1'b0;
                        end
                    end
                end
                // Only a rebiased underflow halts; plain register results go on.
                if (q.uf && !q.mask && q.op.to_reg) begin
                    d.irq = 1'b1;
                    d.st  = ST_HALT;
                end
            end
            ST_HALT: begin
                if (resume_i) begin
                    d.irq = 1'b0;
                    d.st  = ST_IDLE;
                end
            end
            default: d.st = ST_IDLE;
        endcase
        if (q.st == ST_IDLE && in_valid_i && in_uf) begin
            d.sticky = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign in_ready_o  = (q.st == ST_IDLE);
    assign out_valid_o = q.oval;
    assign out_o       = q.res;
    assign irq_o       = q.irq;
    assign halted_o    = (q.st == ST_HALT);
    assign uf_sticky_o = q.sticky;

    ////////////////////////////////////////////////////////////////////////

    property p_uf_sticky;
        @(posedge clk_i) disable iff (!reset_n_i)
        (q.st == ST_IDLE && in_valid_i && in_uf) |=> uf_sticky_o;
    endproperty
    a_uf_sticky: assert property (p_uf_sticky) else $error("sticky not set");

    property p_mem_halt;
        @(posedge clk_i) disable iff (!reset_n_i)
        (in_ready_o && in_valid_i && in_uf && !uf_mask_i && !in_i.to_reg)
            |=> (halted_o && irq_o && !out_valid_o);
    endproperty
    a_mem_halt: assert property (p_mem_halt) else $error("memory underflow not halted");

    property p_reg_irq;
        @(posedge clk_i) disable iff (!reset_n_i)
        (in_ready_o && in_valid_i && in_uf && !uf_mask_i && in_i.to_reg)
            |=> ##1 (out_valid_o && out_o.exp == $past(in_i.exp, 2) + FPUD_REBIAS)
            ##1 (irq_o && halted_o);
    endproperty
    a_reg_irq: assert property (p_reg_irq) else $error("register rebias path wrong");

    property p_masked_go;
        @(posedge clk_i) disable iff (!reset_n_i)
        (out_valid_o && q.mask) |-> !irq_o;
    endproperty
    a_masked_go: assert property (p_masked_go) else $error("masked underflow interrupted");

    property p_step;
        @(posedge clk_i) disable iff (!reset_n_i)
        (q.st == ST_DNRM && q.op.exp < q.emin)
            |=> (q.op.exp == $past(q.op.exp) + 18'sd1 && !q.op.sig[FPUD_SIG_W-1]);
    endproperty
    a_step: assert property (p_step) else $error("denormal step wrong");

    property p_zero_tag;
        @(posedge clk_i) disable iff (!reset_n_i)
        (out_valid_o && out_o.sig == 64'h0) |-> (out_o.tag == FPUD_TAG_ZERO && out_o.exp == '0);
    endproperty
    a_zero_tag: assert property (p_zero_tag) else $error("zero not tagged");

    property p_den_tag;
        @(posedge clk_i) disable iff (!reset_n_i)
        (out_valid_o && out_o.denorm) |-> (out_o.tag == FPUD_TAG_SPECIAL && out_o.sig != 64'h0);
    endproperty
    a_den_tag: assert property (p_den_tag) else $error("denormal not special");

    property p_den_exp;
        @(posedge clk_i) disable iff (!reset_n_i)
        (out_valid_o && out_o.denorm && !out_o.sig[FPUD_SIG_W-1]) |-> out_o.exp == '0;
    endproperty
    a_den_exp: assert property (p_den_exp) else $error("denormal exponent not zero");

    property p_plain_go;
        @(posedge clk_i) disable iff (!reset_n_i)
        (in_ready_o && in_valid_i && !in_uf) |=> ##1 (out_valid_o && !irq_o && !halted_o);
    endproperty
    a_plain_go: assert property (p_plain_go) else $error("plain result interrupted");

endmodule : fpud_core

`default_nettype wire

/* File: fpud_arith_model.sv */
/*
 * Model of the arithmetic core and register stack around the stage.
 * Assumes the bench pulses req_i only while the stage is idle.
 */
`default_nettype none

module fpud_arith_model
    import fpud_pkg::*;
(
    input  wire logic       clk_i,       // Clock.
    input  wire logic       reset_n_i,   // Sync reset, active low.
    input  wire logic       req_i,       // Offer one operand.
    input  wire fpud_opnd_t opnd_i,      // Operand to offer.
    input  wire logic       in_ready_i,  // Stage accepts.
    output logic            in_valid_o,  // Operand offered.
    output fpud_opnd_t      in_o,        // Operand bus.
    input  wire logic       out_valid_i, // Result pulse.
    input  wire fpud_res_t  out_i,       // Result.
    output fpud_res_t       last_o,      // Last result taken.
    output int              n_res_o      // Results taken.
);
    timeunit 1ns;
    timeprecision 100ps;

    // The released bus is inverted so a stale operand is never reused.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            in_valid_o <= 1'b0;
            in_o       <= '0;
            last_o     <= '0;
            n_res_o    <= 0;
        end else begin
            if (req_i) begin
                in_valid_o <= 1'b1;
                in_o       <= opnd_i;
            end else if (in_valid_o && in_ready_i) begin
                in_valid_o <= 1'b0;
                in_o       <= fpud_opnd_t'(~in_o);
            end
            if (out_valid_i) begin
                last_o  <= out_i;
                n_res_o <= n_res_o + 1;
            end
        end
    end

endmodule : fpud_arith_model

`default_nettype wire

/* File: testbench.sv */
/*
 * Self-checking bench for the underflow stage.
 * Assumes the stage and the arithmetic model sit in the same folder.
 */
`default_nettype none

module testbench
    import fpud_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_i = 1'b0, reset_n_i = 1'b0, req = 1'b0, uf_mask = 1'b0;
    logic uf_clear = 1'b0, resume = 1'b0, in_valid, in_ready, out_valid;
    logic irq, halted, sticky;
    fpud_opnd_t opnd = '0, in_bus;
    fpud_res_t  out_bus, last;
    int         n_res, num_errors = 0, checked = 0;
    bit         got;

    always #2.5 clk_i = ~clk_i;

    fpud_core DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .in_valid_i(in_valid),
        .in_ready_o(in_ready), .in_i(in_bus), .uf_mask_i(uf_mask), .uf_clear_i(uf_clear),
        .resume_i(resume), .out_valid_o(out_valid), .out_o(out_bus), .irq_o(irq),
        .halted_o(halted), .uf_sticky_o(sticky));

    fpud_arith_model MDL (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req), .opnd_i(opnd),
        .in_ready_i(in_ready), .in_valid_o(in_valid), .in_o(in_bus), .out_valid_i(out_valid),
        .out_i(out_bus), .last_o(last), .n_res_o(n_res));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    task automatic cmp_val(input logic [81:0] g, input logic [81:0] e, input string m);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("BAD t=%0t %s", $time, m);
        end
    endtask : cmp_val

    task automatic cmp_res(input logic [17:0] e, input logic [63:0] s, input logic [1:0] t);
        checked++;
        if ({last.exp, last.sig, last.tag} !== {e, s, t}) begin
            num_errors++;
            $display("BAD t=%0t result %h %h %h", $time, last.exp, last.sig, last.tag);
        end
    endtask : cmp_res

    // Offers one operand and waits a bounded time for a result.
    task automatic run(input fpud_fmt_t f, input logic signed [17:0] e, input logic [63:0] s,
                       input logic r, input logic m);
        int n0;
        n0 = n_res;
        got = 1'b0;
        opnd = '{sign: 1'b0, exp: e, sig: s, fmt: f, to_reg: r};
        uf_mask = m;
        req = 1'b1;
        @(posedge clk_i); #1;
        req = 1'b0;
        for (int i = 0; i < 100 && !got; i++) begin
            @(posedge clk_i); #1;
            got = (n_res != n0);
        end
    endtask : run

    // Pulses resume when rsm is set, the sticky clear otherwise.
    task automatic pulse(input bit rsm);
        if (rsm) begin
            resume = 1'b1;
        end else begin
            uf_clear = 1'b1;
        end
        @(posedge clk_i); #1;
        resume = 1'b0;
        uf_clear = 1'b0;
        @(posedge clk_i); #1;
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_boundary();
        fpud_fmt_t          f[3] = '{FPUD_DST_SINGLE, FPUD_DST_DOUBLE, FPUD_DST_EXTEND};
        logic signed [17:0] e[3] = '{FPUD_EMIN_SINGLE, FPUD_EMIN_DOUBLE, FPUD_EMIN_EXTEND};
        for (int i = 0; i < 3; i++) begin
            run(f[i], e[i], 64'hc000_0000_0000_0000, 1'b1, 1'b1);
            cmp_val(82'(got), 82'h1, "no result");
            cmp_res(e[i], 64'hc000_0000_0000_0000, FPUD_TAG_VALID);
            cmp_val(82'(sticky), 82'h0, "false underflow");
        end
    endtask : t_boundary

    task automatic t_masked();
        run(FPUD_DST_DOUBLE, -18'sd1025, 64'h8000_0000_0000_0001, 1'b1, 1'b1);
        cmp_val(82'(got), 82'h1, "no result");
        cmp_res(18'h0, 64'h2000_0000_0000_0000, FPUD_TAG_SPECIAL);
        cmp_val(82'(last.denorm), 82'h1, "denorm flag");
        cmp_val(82'({irq, halted, sticky}), 82'h1, "masked flags");
        pulse(1'b0);
        cmp_val(82'(sticky), 82'h0, "sticky not cleared");
    endtask : t_masked

    task automatic t_single();
        run(FPUD_DST_SINGLE, -18'sd127, 64'h8000_0100_0000_0000, 1'b0, 1'b1);
        cmp_val(82'(got), 82'h1, "no store");
        cmp_res(18'h0, 64'h4000_0100_0000_0000, FPUD_TAG_SPECIAL);
        run(FPUD_DST_SINGLE, -18'sd127, 64'hffff_ff00_0000_0000, 1'b0, 1'b1);
        cmp_val(82'(got), 82'h1, "no store");
        cmp_res(FPUD_EMIN_SINGLE, 64'h8000_0000_0000_0000, FPUD_TAG_VALID);
        cmp_val(82'({last.denorm, irq, halted}), 82'h0, "carry flags");
    endtask : t_single

    task automatic t_zero();
        run(FPUD_DST_EXTEND, -18'sd16447, 64'h8000_0000_0000_0000, 1'b1, 1'b1);
        cmp_val(82'(got), 82'h1, "no result");
        cmp_res(18'h0, 64'h0, FPUD_TAG_ZERO);
    endtask : t_zero

    task automatic t_unmasked_mem();
        run(FPUD_DST_DOUBLE, -18'sd1024, 64'h8000_0000_0000_0000, 1'b0, 1'b0);
        cmp_val(82'(got), 82'h0, "store completed");
        cmp_val(82'({irq, halted, in_ready, sticky}), 82'hd, "halt");
        pulse(1'b1);
        cmp_val(82'({irq, halted}), 82'h0, "halt not left");
        pulse(1'b0);
    endtask : t_unmasked_mem

    task automatic t_unmasked_reg();
        run(FPUD_DST_DOUBLE, FPUD_EMIN_DOUBLE, 64'h8000_0000_0000_0000, 1'b1, 1'b0);
        cmp_val(82'({got, irq, halted}), 82'h4, "plain result halted");
        run(FPUD_DST_DOUBLE, -18'sd1100, 64'h8000_0000_0000_0000, 1'b1, 1'b0);
        cmp_val(82'(got), 82'h1, "no register write");
        cmp_val(82'(last.exp), 82'(18'(-1100 + 24576)), "rebias");
        @(posedge clk_i); #1;
        @(posedge clk_i); #1;
        cmp_val(82'({irq, halted}), 82'h3, "no interrupt");
        pulse(1'b1);
    endtask : t_unmasked_reg

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk_i);
        #1;
        reset_n_i = 1'b1;
        @(posedge clk_i); #1;
        t_boundary();
        t_masked();
        t_single();
        t_unmasked_mem();
        t_unmasked_reg();
        t_zero();
        results();
    end

    // The tests need well under 2000 cycles; this bounds a hang.
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        results();
    end

endmodule : testbench

`default_nettype wire
